// file: hdl/rist_sequencer.sv
// Design decisions made here: the APB register port and the register addresses.
module rist_sequencer
    import rist_pkg::*;
#(
    parameter int NPORTS = 5
)(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // straps and halt pin
    input  wire logic [3:0]        op_mode_straps,
    input  wire logic              reset_halt_pin,
    // eeprom stream
    input  wire logic              rom_valid,
    input  wire logic              rom_last,
    input  wire logic [2:0]        rom_err,
    input  wire logic [7:0]        rom_addr,
    input  wire logic [31:0]       rom_data,
    // port link status
    input  wire logic [NPORTS-1:0] port_trained,
    input  wire logic [NPORTS-1:0] port_no_partner,
    input  wire logic [NPORTS-1:0] port_compliance,
    input  wire logic [NPORTS-1:0] port_ts1_seen,
    input  wire logic [NPORTS-1:0] port_detect_entry,
    // outputs to the device core
    output logic [NPORTS-1:0]      cfg_retry_only,
    output logic                   core_reset_n,
    output logic                   normal_op,
    output logic                   irq
);
    rist_state_t       state;
    logic [3:0]        mode;
    logic              strap_taken;
    logic              halt_ctl;
    logic              halt_sts;
    logic              done_flag;
    logic [2:0]        err_info;
    logic [31:0]       rom_access;
    logic [IRQ_W-1:0]  irq_sts;
    logic [IRQ_W-1:0]  irq_mask;
    logic [IRQ_W-1:0]  events;
    logic [NPORTS-1:0] port_done;
    logic [NPORTS-1:0] port_ok;
    logic              ld_wr, ld_busy, ld_fin, ld_err;
    logic [7:0]        ld_addr;
    logic [31:0]       ld_data;
    logic [2:0]        ld_code;
    logic              wr_acc;
    logic              load_start;
    logic              train_clear;

    function automatic logic needs_rom(input logic [3:0] m);
        return m == MODE_EEPROM;
    endfunction

    assign wr_acc      = psel && penable && pwrite;
    assign load_start  = state == SQ_IDLE && strap_taken && needs_rom(mode);
    assign train_clear = state == SQ_IDLE;

    rist_rom_loader u_loader (
        .pclk     (pclk),
        .presetn  (presetn),
        .start    (load_start),
        .rom_valid(rom_valid),
        .rom_last (rom_last),
        .rom_err  (rom_err),
        .rom_addr (rom_addr),
        .rom_data (rom_data),
        .wr_en    (ld_wr),
        .wr_addr  (ld_addr),
        .wr_data  (ld_data),
        .busy     (ld_busy),
        .fin      (ld_fin),
        .err      (ld_err),
        .err_code (ld_code)
    );

    for (genvar p = 0; p < NPORTS; p++)
    begin : g_port
        rist_port_watch u_watch (
            .pclk        (pclk),
            .presetn     (presetn),
            .clear       (train_clear),
            .trained     (port_trained[p]),
            .no_partner  (port_no_partner[p]),
            .compliance  (port_compliance[p]),
            .ts1_seen    (port_ts1_seen[p]),
            .detect_entry(port_detect_entry[p]),
            .done        (port_done[p]),
            .ready_ok    (port_ok[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // straps caught one clock after reset release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode        <= 4'h0;
            strap_taken <= 1'b0;
        end
        else if (!strap_taken)
        begin
            mode        <= op_mode_straps;
            strap_taken <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= SQ_IDLE;
        else
        begin
            case (state)
                SQ_IDLE:
                    if (strap_taken)
                        state <= needs_rom(mode) ? SQ_LOAD : SQ_TRAIN;
                SQ_LOAD:
                    if (ld_fin)
                        state <= SQ_TRAIN;
                // halt checked only when training ends, after the load if the mode has one
                SQ_TRAIN:
                    if (&port_done)
                        state <= (halt_ctl || halt_sts) ? SQ_HALT : SQ_RUN;
                SQ_HALT:
                    if (!halt_ctl && !halt_sts)
                        state <= SQ_RUN;
                SQ_RUN:
                    state <= SQ_RUN;
                default:
                    state <= SQ_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core control; core in reset, trained ports retry-only until run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_reset_n   <= 1'b0;
            normal_op      <= 1'b0;
            cfg_retry_only <= '0;
        end
        else
        begin
            core_reset_n <= state == SQ_RUN;
            normal_op    <= state == SQ_RUN;
            if (state == SQ_RUN)
                cfg_retry_only <= '0;
            else
                cfg_retry_only <= port_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            halt_ctl   <= 1'b0;
            halt_sts   <= 1'b0;
            done_flag  <= 1'b0;
            err_info   <= 3'h0;
            rom_access <= RESET_WORD;
            irq_mask   <= '0;
        end
        else
        begin
            // load error sets halt; agent write clears it
            if (ld_err)
                halt_ctl <= 1'b1;
            else if (wr_acc && paddr == SWITCH_CONTROL_OFS)
                halt_ctl <= pwdata[HALT_BIT];
            else if (ld_wr && ld_addr == SWITCH_CONTROL_OFS)
                halt_ctl <= ld_data[HALT_BIT];
            // pin sets status halt in idle, load and train only; write-one clears it
            if (reset_halt_pin && state != SQ_RUN && state != SQ_HALT)
                halt_sts <= 1'b1;
            else if (wr_acc && paddr == SWITCH_STATUS_OFS && pwdata[HALT_BIT])
                halt_sts <= 1'b0;
            if (ld_fin)
                done_flag <= 1'b1;
            if (ld_err)
                err_info <= ld_code;
            if (wr_acc && paddr == ROM_ACCESS_OFS)
                rom_access <= pwdata;
            else if (ld_wr && ld_addr == ROM_ACCESS_OFS)
                rom_access <= ld_data;
            if (wr_acc && paddr == IRQ_MASK_OFS)
                irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts, set wins over write-one-clear
    // bit 3 pulses on the first run cycle, before normal_op follows
    assign events = {state == SQ_RUN && !normal_op, &port_done && state == SQ_TRAIN,
                     ld_err, ld_fin};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_sts <= '0;
            irq     <= 1'b0;
        end
        else
        begin
            if (wr_acc && paddr == IRQ_STATUS_OFS)
                irq_sts <= (irq_sts & ~pwdata[IRQ_W-1:0]) | events;
            else
                irq_sts <= irq_sts | events;
            irq <= |(irq_sts & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb: one wait-free access, read data set up during setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                prdata <= 32'h0000_0000;
                if (paddr == SWITCH_CONTROL_OFS)
                    prdata[HALT_BIT] <= halt_ctl;
                else if (paddr == SWITCH_STATUS_OFS)
                    prdata <= {25'h0, state, 3'h0, halt_sts};
                else if (paddr == SERIAL_STATUS_OFS)
                    prdata[3:0] <= {err_info, done_flag};
                else if (paddr == ROM_ACCESS_OFS)
                    prdata <= rom_access;
                else if (paddr == IRQ_STATUS_OFS)
                    prdata[IRQ_W-1:0] <= irq_sts;
                else if (paddr == IRQ_MASK_OFS)
                    prdata[IRQ_W-1:0] <= irq_mask;
                else if (paddr == PORT_STATE_OFS)
                    prdata[NPORTS-1:0] <= port_done;
                else
                    pslverr <= 1'b1;
            end
        end
    end

    halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == SQ_HALT && halt_ctl) |=> state == SQ_HALT) else $error("left halt early");
    err_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        ld_err |=> (halt_ctl && done_flag && err_info == $past(ld_code)))
        else $error("error not recorded");
    order_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == SQ_TRAIN) |-> !ld_busy) else $error("train wait during load");
    run_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == SQ_RUN) |=> (normal_op && core_reset_n)) else $error("run not signalled");
    core_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == SQ_HALT) |=> !core_reset_n) else $error("core out of reset while halted");
    pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        (reset_halt_pin && state == SQ_TRAIN) |=> halt_sts) else $error("pin halt lost");
    done_a: assert property (@(posedge pclk) disable iff (!presetn)
        ld_fin |=> done_flag) else $error("done flag missing");
    retry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == SQ_TRAIN && !port_ok[0]) |=> !cfg_retry_only[0]) else $error("retry bad");
endmodule // rist_sequencer

// file: hdl/rist_pkg.sv
package rist_pkg;
    // apb byte offsets
    localparam logic [7:0] SWITCH_CONTROL_OFS = 8'h00;
    localparam logic [7:0] SWITCH_STATUS_OFS  = 8'h04;
    localparam logic [7:0] SERIAL_STATUS_OFS  = 8'h08;
    localparam logic [7:0] ROM_ACCESS_OFS     = 8'h0c;
    localparam logic [7:0] IRQ_STATUS_OFS     = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS       = 8'h14;
    localparam logic [7:0] PORT_STATE_OFS     = 8'h18;
    // field positions
    localparam int HALT_BIT      = 0;
    localparam int DONE_BIT      = 0;
    localparam int ERR_LSB       = 1;
    localparam int PHASE_LSB     = 4;
    // interrupt events
    localparam int IRQ_LOAD_DONE = 0;
    localparam int IRQ_LOAD_ERR  = 1;
    localparam int IRQ_TRAIN_END = 2;
    localparam int IRQ_RUNNING   = 3;
    localparam int IRQ_W         = 4;
    // modes needing eeprom setup
    localparam logic [3:0] MODE_EEPROM = 4'h1;
    localparam int         FAIL_LIMIT  = 16;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef enum logic [2:0] {SQ_IDLE, SQ_LOAD, SQ_TRAIN, SQ_HALT, SQ_RUN} rist_state_t;
endpackage

// file: hdl/rist_port_watch.sv
module rist_port_watch
    import rist_pkg::*;
#(
    parameter int LIMIT = FAIL_LIMIT
)(
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clear,
    // link state from the port
    input  wire logic trained,
    input  wire logic no_partner,
    input  wire logic compliance,
    input  wire logic ts1_seen,
    input  wire logic detect_entry,
    // result
    output logic      done,
    output logic      ready_ok
);
    logic [4:0] fail_cnt;
    logic       ts1_this_try;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fail_cnt     <= 5'h00;
            ts1_this_try <= 1'b0;
        end
        else if (clear || trained)
        begin
            fail_cnt     <= 5'h00;
            ts1_this_try <= 1'b0;
        end
        else if (detect_entry)
        begin
            if (ts1_this_try && fail_cnt < 5'(LIMIT))
                fail_cnt <= fail_cnt + 5'h01;
            else if (!ts1_this_try)
                fail_cnt <= 5'h00;
            ts1_this_try <= 1'b0;
        end
        else if (ts1_seen)
            ts1_this_try <= 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done     <= 1'b0;
            ready_ok <= 1'b0;
        end
        else if (clear)
        begin
            done     <= 1'b0;
            ready_ok <= 1'b0;
        end
        else
        begin
            if (trained || no_partner || compliance || fail_cnt >= 5'(LIMIT))
                done <= 1'b1;
            ready_ok <= trained;
        end
    end

    count_a: assert property (@(posedge pclk) disable iff (!presetn)
        fail_cnt <= 5'(LIMIT)) else $error("fail count overran");
    end_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!clear && fail_cnt == 5'(LIMIT)) |=> done) else $error("failure not ended");
endmodule // rist_port_watch

// file: hdl/rist_rom_loader.sv
module rist_rom_loader
    import rist_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    // eeprom word stream from master smbus
    input  wire logic        rom_valid,
    input  wire logic        rom_last,
    input  wire logic [2:0]  rom_err,
    input  wire logic [7:0]  rom_addr,
    input  wire logic [31:0] rom_data,
    // register update and result
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data,
    output logic             busy,
    output logic             fin,
    output logic             err,
    output logic [2:0]       err_code
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            fin <= 1'b0;
            err <= 1'b0;
            err_code <= 3'h0;
            wr_en <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
        end
        else
        begin
            fin   <= 1'b0;
            err   <= 1'b0;
            wr_en <= 1'b0;
            if (start)
                busy <= 1'b1;
            else if (busy && rom_err != 3'h0)
            begin
                busy     <= 1'b0;
                err      <= 1'b1;
                fin      <= 1'b1;
                err_code <= rom_err;
            end
            else if (busy && rom_valid)
            begin
                wr_en   <= 1'b1;
                wr_addr <= rom_addr;
                wr_data <= rom_data;
                if (rom_last)
                begin
                    busy <= 1'b0;
                    fin  <= 1'b1;
                end
            end
        end
    end

    abort_a: assert property (@(posedge pclk) disable iff (!presetn)
        (busy && !start && rom_err != 3'h0) |=> (err && fin && !busy && !wr_en))
        else $error("error did not abort");
endmodule // rist_rom_loader

// file: tb/rist_rom_model.sv
module rist_rom_model
    import rist_pkg::*;
(
    // clock and trigger
    input  wire logic        pclk,
    input  wire logic        go,
    input  wire logic [2:0]  fault,
    // eeprom word stream
    output logic             rom_valid,
    output logic             rom_last,
    output logic [2:0]       rom_err,
    output logic [7:0]       rom_addr,
    output logic [31:0]      rom_data
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ROM_WORD = 32'h5a5a_c3c3;
    int step = 0;
    initial {rom_valid, rom_last, rom_err, rom_addr, rom_data} = '0;
    ////////////////////////////////////////////////////////////////
    // two words, slow gaps
    // released data flips so a stale word never looks valid
    always @(posedge pclk)
    begin
        rom_valid <= 1'b0;
        rom_last  <= 1'b0;
        rom_err   <= 3'h0;
        rom_data  <= ~rom_data;
        if (go)
            step <= 1;
        else if (step != 0)
            step <= step + 1;
        if (step == 4)
        begin
            rom_valid <= 1'b1;
            rom_addr  <= ROM_ACCESS_OFS;
            rom_data  <= ROM_WORD;
        end
        if (step == 7)
        begin
            rom_valid <= 1'b1;
            rom_last  <= 1'b1;
            rom_addr  <= SWITCH_CONTROL_OFS;
            rom_data  <= 32'h0;
            rom_err   <= fault;
            step      <= 0;
        end
    end
endmodule // rist_rom_model

// file: tb/reset_init_sequencer_tail_tb.sv
module reset_init_sequencer_tail_tb
    import rist_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, err_seen;
    logic [3:0]  op_mode_straps = 4'h0;
    logic        reset_halt_pin = 1'b0, go = 1'b0;
    logic [2:0]  fault = 3'h0;
    logic        rom_valid, rom_last;
    logic [2:0]  rom_err;
    logic [7:0]  rom_addr;
    logic [31:0] rom_data;
    logic [4:0]  p_tr = '0, p_np = '0, p_cp = '0, p_ts = '0, p_de = '0;
    logic [4:0]  cfg_retry_only;
    logic        core_reset_n, normal_op, irq;
    int          fails = 0, compares = 0;

    always #4 pclk = ~pclk;

    rist_sequencer #(.NPORTS(5)) i_rist_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .op_mode_straps(op_mode_straps), .reset_halt_pin(reset_halt_pin),
        .rom_valid(rom_valid), .rom_last(rom_last), .rom_err(rom_err),
        .rom_addr(rom_addr), .rom_data(rom_data),
        .port_trained(p_tr), .port_no_partner(p_np), .port_compliance(p_cp),
        .port_ts1_seen(p_ts), .port_detect_entry(p_de),
        .cfg_retry_only(cfg_retry_only), .core_reset_n(core_reset_n),
        .normal_op(normal_op), .irq(irq));

    rist_rom_model i_rist_rom_model (
        .pclk(pclk), .go(go), .fault(fault), .rom_valid(rom_valid), .rom_last(rom_last),
        .rom_err(rom_err), .rom_addr(rom_addr), .rom_data(rom_data));

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // one idle cycle after each transfer keeps strobes single-driven
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q        = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        apb(1'b0, a, 32'h0, q);
    endtask

    task automatic do_reset(input logic [3:0] mode);
        presetn        <= 1'b0;
        op_mode_straps <= mode;
        reset_halt_pin <= 1'b0;
        {p_tr, p_np, p_cp, p_ts, p_de} <= '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    task automatic run_load(input logic [2:0] f, output logic [31:0] q);
        fault <= f;
        go    <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (40)
        begin
            rd(SERIAL_STATUS_OFS, q);
            if (q[DONE_BIT] === 1'b1)
                break;
        end
    endtask

    task automatic wait_run();
        repeat (60)
        begin
            if (normal_op === 1'b1)
                break;
            @(posedge pclk);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_train();
        logic [31:0] q;
        do_reset(4'h0);
        repeat (4) @(posedge pclk);
        chk("normal_op", 0, normal_op);
        p_tr[0] <= 1'b1;
        p_np[1] <= 1'b1;
        p_cp[2] <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("cfg_retry_only", 1, cfg_retry_only[1:0]);
        for (int i = 1; i <= 16; i++)
        begin
            p_ts[3] <= 1'b1;
            @(posedge pclk);
            p_ts[3] <= 1'b0;
            p_de[3] <= 1'b1;
            @(posedge pclk);
            p_de[3] <= 1'b0;
            @(posedge pclk);
            rd(PORT_STATE_OFS, q);
            if (i >= 15)
                chk("port_done", (i == 16) ? 32'hf : 32'h7, q[4:0]);
        end
        chk("normal_op", 0, normal_op);
        p_tr[4] <= 1'b1;
        wait_run();
        chk("core_reset_n", 1, core_reset_n);
        chk("normal_op", 1, normal_op);
        rd(8'h1c, q);
        chk("pslverr", 1, err_seen);
        $display("t_train done");
    endtask

    task automatic t_load();
        logic [31:0] q;
        do_reset(4'h1);
        wr(IRQ_MASK_OFS, 32'h1);
        rd(SERIAL_STATUS_OFS, q);
        chk("load_done", 0, q[DONE_BIT]);
        run_load(3'h0, q);
        chk("serial_status", 32'h1, q[3:0]);
        rd(SERIAL_STATUS_OFS, q);
        chk("serial_status", 32'h1, q[3:0]);
        rd(ROM_ACCESS_OFS, q);
        chk("rom_access", 32'h5a5a_c3c3, q);
        chk("irq", 1, irq);
        wr(IRQ_STATUS_OFS, 32'h1);
        // irq is registered from the status, one edge behind the clear
        @(posedge pclk);
        chk("irq", 0, irq);
        p_tr <= 5'h1f;
        wait_run();
        chk("normal_op", 1, normal_op);
        rd(IRQ_STATUS_OFS, q);
        chk("train_end", 1, q[IRQ_TRAIN_END]);
        chk("running", 1, q[IRQ_RUNNING]);
        chk("irq", 0, irq);
        $display("t_load done");
    endtask

    task automatic t_fail();
        logic [31:0] q;
        do_reset(4'h1);
        run_load(3'h5, q);
        rd(SERIAL_STATUS_OFS, q);
        chk("serial_status", 32'hb, q[3:0]);
        rd(SWITCH_CONTROL_OFS, q);
        chk("reset_halt", 1, q[HALT_BIT]);
        p_tr <= 5'h1f;
        repeat (20) @(posedge pclk);
        chk("normal_op", 0, normal_op);
        chk("core_reset_n", 0, core_reset_n);
        chk("cfg_retry_only", 32'h1f, cfg_retry_only);
        wr(ROM_ACCESS_OFS, 32'h1234_abcd);
        rd(ROM_ACCESS_OFS, q);
        chk("rom_access", 32'h1234_abcd, q);
        wr(SWITCH_CONTROL_OFS, 32'h0);
        wait_run();
        chk("normal_op", 1, normal_op);
        $display("t_fail done");
    endtask

    task automatic t_pin();
        logic [31:0] q;
        do_reset(4'h0);
        reset_halt_pin <= 1'b1;
        repeat (3) @(posedge pclk);
        rd(SWITCH_STATUS_OFS, q);
        chk("halt_status", 1, q[HALT_BIT]);
        p_tr <= 5'h1f;
        repeat (20) @(posedge pclk);
        chk("normal_op", 0, normal_op);
        reset_halt_pin <= 1'b0;
        wr(SWITCH_STATUS_OFS, 32'h1);
        wait_run();
        chk("normal_op", 1, normal_op);
        $display("t_pin done");
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        t_train();
        t_load();
        t_fail();
        t_pin();
        wrap_up();
    end

    // all four tests need well under this
    initial
    begin
        repeat (20000) @(posedge pclk);
        fails++;
        wrap_up();
    end
endmodule // reset_init_sequencer_tail_tb
